//--- design/sleep_power_control.sv
// sleep, brown-out sleep disable and peripheral clock gate control
// assumes synchronous inputs on clk; the cpu raises sleep_request for one cycle on a sleep
// instruction and wake_request while an enabled interrupt is pending
`timescale 1ns/10ps
`default_nettype none

module sleep_power_control #(
    parameter int BOD_WAKE_CYCLES_P = sleep_power_pkg::BOD_WAKE_CYCLES,
    parameter int STARTUP_CYCLES_P  = sleep_power_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    // register port
    input  wire sleep_power_pkg::avalon_req_t    avs_req,
    output var  sleep_power_pkg::avalon_rsp_t    avs_rsp,
    // cpu side
    input  wire logic                            sleep_request,
    input  wire logic                            wake_request,
    output logic                                 cpu_halt,
    output logic                                 wake_resume,
    // clock tree and detector
    output var  sleep_power_pkg::clock_enables_t clock_enable,
    output logic                                 brownout_detector_enable,
    // peripheral register access
    output logic                                 timer_io_access,
    output logic                                 adc_io_access,
    // analog side
    input  wire logic                            adc_enabled,
    input  wire logic                            adc_conversion_start,
    input  wire logic                            comparator_uses_bandgap,
    output logic                                 adc_extended_conversion,
    output logic                                 comparator_enable,
    // port pins
    input  wire logic [sleep_power_pkg::PIN_COUNT-1:0] wake_pin_mask,
    output logic [sleep_power_pkg::PIN_COUNT-1:0]      input_buffer_enable
);
    import sleep_power_pkg::*;

    localparam logic [12:0] BOD_WAKE_LOAD = 13'(BOD_WAKE_CYCLES_P - 1);
    localparam logic [12:0] STARTUP_LOAD  = 13'(STARTUP_CYCLES_P - 1);

    typedef struct packed {
        logic         done;
        logic [31:0]  rdata;
        logic [2:0]   unlock_cnt;
        logic [2:0]   off_cnt;
        logic         arm;
        logic [1:0]   mode;
        logic         timer_stop;
        logic         adc_stop;
        power_state_t pst;
        logic [12:0]  wcnt;
        logic         bod_off_sleep;
        logic         adc_en_q;
        logic         adc_ext;
        logic         resume;
    } state_t;

    state_t s;
    state_t next_s;

    logic        access;
    logic        wr_take;
    logic [7:0]  wbyte;
    logic        off_effective;
    logic        deep_sleep;
    logic        awake;
    logic [31:0] rd_mux;
    logic        unlock_open;
    logic        off_pending;
    logic        sleep_take;
    logic        count_done;
    logic        adc_rise;
    logic [7:0]  bod_word;
    logic [7:0]  sleep_word;
    logic [7:0]  gate_word;
    logic [7:0]  status_word;

    assign access        = avs_req.read | avs_req.write;
    assign wr_take       = avs_req.write & s.done & avs_req.byteenable[0];
    assign wbyte         = avs_req.writedata[7:0];
    assign off_effective = (s.off_cnt != RST_COUNT3) && (s.off_cnt <= OFF_HOLD_3);
    assign awake         = (s.pst != ST_SLEEP);
    // io and adc clocks both stopped only in power-down
    assign deep_sleep    = (s.pst == ST_SLEEP) && (s.mode == MODE_POWER_DOWN);
    // a count of zero means closed; the lapse of the unlock and the self-clear of the
    // off bit share one down-counter form, so both end on the same kind of edge
    assign unlock_open   = (s.unlock_cnt != RST_COUNT3);
    assign off_pending   = (s.off_cnt != RST_COUNT3);
    // reserved mode code is treated as no sleep, so the cpu never halts on it
    assign sleep_take    = sleep_request && s.arm && (s.mode != MODE_RESERVED);
    // wake and halt phases both count down to zero in the same counter
    assign count_done    = (s.wcnt == RST_COUNT13);
    assign adc_rise      = adc_enabled && !s.adc_en_q;

    // register images, reserved positions stay zero
    always_comb begin
        bod_word                            = 8'h00;
        bod_word[BIT_DETECTOR_SLEEP_OFF]    = off_pending;
        bod_word[BIT_DETECTOR_SLEEP_UNLOCK] = unlock_open;
    end

    always_comb begin
        sleep_word                      = 8'h00;
        sleep_word[BIT_SLEEP_ARM]       = s.arm;
        sleep_word[LSB_SLEEP_MODE +: 2] = s.mode;
    end

    always_comb begin
        gate_word                       = 8'h00;
        gate_word[BIT_TIMER_CLOCK_STOP] = s.timer_stop;
        gate_word[BIT_ADC_CLOCK_STOP]   = s.adc_stop;
    end

    always_comb begin
        status_word                      = 8'h00;
        status_word[BIT_ST_AWAKE]        = (s.pst == ST_ACTIVE);
        status_word[BIT_ST_SLEEPING]     = (s.pst == ST_SLEEP);
        status_word[BIT_ST_DETECTOR_ON]  = brownout_detector_enable;
        status_word[BIT_ST_OFF_ARMED]    = off_effective;
        status_word[BIT_ST_UNLOCKED]     = unlock_open;
        status_word[BIT_ST_ADC_EXTENDED] = s.adc_ext;
    end

    // one wait state: data is registered while waitrequest is high
    always_comb begin
        rd_mux = RST_WORD;
        case (avs_req.address)
            OFS_BROWNOUT_SLEEP_CONTROL: begin
                rd_mux[7:0] = bod_word;
            end
            OFS_SLEEP_CONTROL: begin
                rd_mux[7:0] = sleep_word;
            end
            OFS_PERIPHERAL_CLOCK_GATE: begin
                rd_mux[7:0] = gate_word;
            end
            OFS_POWER_STATUS: begin
                rd_mux[7:0] = status_word;
            end
            default: begin
                rd_mux = RST_WORD;
            end
        endcase
    end

    always_comb begin
        next_s        = s;
        next_s.resume = 1'b0;

        // bus handshake
        next_s.done = access & ~s.done;
        if (access && !s.done) begin
            next_s.rdata = avs_req.read ? rd_mux : s.rdata;
        end

        // unlock window and off bit lifetime
        if (unlock_open) begin
            next_s.unlock_cnt = s.unlock_cnt - 3'h1;
        end
        if (off_pending) begin
            next_s.off_cnt = s.off_cnt - 3'h1;
        end

        if (wr_take) begin
            case (avs_req.address)
                OFS_BROWNOUT_SLEEP_CONTROL: begin
                    if (wbyte[BIT_DETECTOR_SLEEP_OFF] && wbyte[BIT_DETECTOR_SLEEP_UNLOCK]) begin
                        next_s.unlock_cnt = UNLOCK_LOAD;
                    end else if (wbyte[BIT_DETECTOR_SLEEP_OFF] && unlock_open) begin
                        next_s.off_cnt    = OFF_LOAD;
                        next_s.unlock_cnt = RST_COUNT3;
                    end
                end
                OFS_SLEEP_CONTROL: begin
                    next_s.arm  = wbyte[BIT_SLEEP_ARM];
                    next_s.mode = wbyte[LSB_SLEEP_MODE +: 2];
                end
                OFS_PERIPHERAL_CLOCK_GATE: begin
                    next_s.timer_stop = wbyte[BIT_TIMER_CLOCK_STOP];
                    next_s.adc_stop   = wbyte[BIT_ADC_CLOCK_STOP];
                end
                default: begin
                    next_s.arm = s.arm;
                end
            endcase
        end

        // adc re-enable tracking: an off-to-on edge forces the next conversion long
        next_s.adc_en_q = adc_enabled;
        if (adc_rise) begin
            next_s.adc_ext = 1'b1;
        end else if (adc_conversion_start) begin
            next_s.adc_ext = 1'b0;
        end

        // sleep sequencer
        case (s.pst)
            ST_ACTIVE: begin
                if (sleep_take) begin
                    next_s.pst = ST_SLEEP;
                    next_s.bod_off_sleep = off_effective && (s.mode == MODE_POWER_DOWN);
                end
            end
            ST_SLEEP: begin
                if (wake_request) begin
                    next_s.pst = ST_WAKE;
                    next_s.bod_off_sleep = 1'b0;
                    next_s.wcnt = s.bod_off_sleep ? BOD_WAKE_LOAD : STARTUP_LOAD;
                end
            end
            ST_WAKE: begin
                if (count_done) begin
                    next_s.pst  = ST_HALT;
                    next_s.wcnt = HALT_LOAD;
                end else begin
                    next_s.wcnt = s.wcnt - 13'h0001;
                end
            end
            ST_HALT: begin
                if (count_done) begin
                    next_s.pst    = ST_ACTIVE;
                    next_s.resume = 1'b1;
                end else begin
                    next_s.wcnt = s.wcnt - 13'h0001;
                end
            end
            default: begin
                next_s.pst = ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.done          <= 1'b0;
            s.rdata         <= RST_WORD;
            s.unlock_cnt    <= RST_COUNT3;
            s.off_cnt       <= RST_COUNT3;
            s.arm           <= RST_SLEEP_ARM;
            s.mode          <= RST_SLEEP_MODE;
            s.timer_stop    <= RST_CLOCK_STOP;
            s.adc_stop      <= RST_CLOCK_STOP;
            s.pst           <= ST_ACTIVE;
            s.wcnt          <= RST_COUNT13;
            s.bod_off_sleep <= 1'b0;
            s.adc_en_q      <= 1'b0;
            s.adc_ext       <= 1'b0;
            s.resume        <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // bus answer
    assign avs_rsp.waitrequest = access & ~s.done;
    assign avs_rsp.readdata    = s.rdata;

    // cpu and detector
    assign cpu_halt    = (s.pst != ST_ACTIVE);
    assign wake_resume = s.resume;
    assign brownout_detector_enable = ~s.bod_off_sleep;

    // clock tree: gate bits only matter while the domain would otherwise run
    always_comb begin
        clock_enable.cpu       = (s.pst == ST_ACTIVE);
        clock_enable.io        = awake || (s.mode == MODE_IDLE);
        clock_enable.adc       = awake || (s.mode != MODE_POWER_DOWN);
        clock_enable.timer     = clock_enable.io && !s.timer_stop;
        clock_enable.adc_gated = clock_enable.adc && !s.adc_stop;
    end

    assign timer_io_access = ~s.timer_stop;
    assign adc_io_access   = ~s.adc_stop;
    assign adc_extended_conversion = s.adc_ext;
    // gated adc also removes the comparator's mux path
    assign comparator_enable = ~s.adc_stop && (~deep_sleep || comparator_uses_bandgap);

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_inbuf
            assign input_buffer_enable[g] = ~deep_sleep | wake_pin_mask[g];
        end
    endgenerate

endmodule : sleep_power_control
`default_nettype wire

//--- design/sleep_power_pkg.sv
// constants, register map and carrier types for the sleep and power control block
// assumes one 125 MHz system clock and a 32-bit Avalon-MM register port
package sleep_power_pkg;

    // register byte offsets on the Avalon-MM port
    localparam logic [3:0] OFS_BROWNOUT_SLEEP_CONTROL = 4'h0;
    localparam logic [3:0] OFS_SLEEP_CONTROL          = 4'h4;
    localparam logic [3:0] OFS_PERIPHERAL_CLOCK_GATE  = 4'h8;
    localparam logic [3:0] OFS_POWER_STATUS           = 4'hC;

    // brownout_sleep_control fields
    localparam int BIT_DETECTOR_SLEEP_OFF    = 1;
    localparam int BIT_DETECTOR_SLEEP_UNLOCK = 0;
    // sleep_control fields
    localparam int BIT_SLEEP_ARM      = 5;
    localparam int LSB_SLEEP_MODE     = 3;
    // peripheral_clock_gate fields
    localparam int BIT_TIMER_CLOCK_STOP = 1;
    localparam int BIT_ADC_CLOCK_STOP   = 0;
    // power_status fields
    localparam int BIT_ST_AWAKE      = 0;
    localparam int BIT_ST_SLEEPING   = 1;
    localparam int BIT_ST_DETECTOR_ON = 2;
    localparam int BIT_ST_OFF_ARMED  = 3;
    localparam int BIT_ST_UNLOCKED   = 4;
    localparam int BIT_ST_ADC_EXTENDED = 5;

    // values after reset
    localparam logic       RST_SLEEP_ARM      = 1'b0;
    localparam logic [1:0] RST_SLEEP_MODE     = 2'h0;
    localparam logic       RST_CLOCK_STOP     = 1'b0;
    localparam logic [2:0] RST_COUNT3         = 3'h0;
    localparam logic [12:0] RST_COUNT13       = 13'h0000;
    localparam logic [31:0] RST_WORD          = 32'h0000_0000;

    // sleep mode select codes
    localparam logic [1:0] MODE_IDLE       = 2'h0;
    localparam logic [1:0] MODE_ADC_NOISE  = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_RESERVED   = 2'h3;

    // timing
    localparam int CLK_MHZ            = 125;
    localparam int UNLOCK_WINDOW      = 4;
    localparam int OFF_DELAY          = 3;
    localparam int OFF_HOLD           = 3;
    localparam int HALT_CYCLES        = 4;
    localparam int BOD_WAKE_US        = 60;
    localparam int BOD_WAKE_CYCLES    = BOD_WAKE_US * CLK_MHZ;
    localparam int STARTUP_CYCLES     = 16;
    localparam int PIN_COUNT          = 6;

    localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_WINDOW);
    localparam logic [2:0] OFF_LOAD    = 3'(OFF_DELAY + OFF_HOLD);
    localparam logic [2:0] OFF_HOLD_3  = 3'(OFF_HOLD);
    localparam logic [12:0] HALT_LOAD  = 13'(HALT_CYCLES - 1);

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'b0001,
        ST_SLEEP  = 4'b0010,
        ST_WAKE   = 4'b0100,
        ST_HALT   = 4'b1000
    } power_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avalon_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avalon_rsp_t;

    typedef struct packed {
        logic cpu;
        logic io;
        logic adc;
        logic timer;
        logic adc_gated;
    } clock_enables_t;

endpackage : sleep_power_pkg

//--- sim/sleep_power_props.sv
// assertions and covers on the ports of the sleep and power control block
// assumes a single clk domain with rst_n as asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module sleep_power_props (
    // clock and reset
    input wire logic                            clk,
    input wire logic                            rst_n,
    // watched ports
    input wire sleep_power_pkg::avalon_req_t    avs_req,
    input wire sleep_power_pkg::avalon_rsp_t    avs_rsp,
    input wire logic                            sleep_request,
    input wire logic                            cpu_halt,
    input wire logic                            wake_resume,
    input wire sleep_power_pkg::clock_enables_t clock_enable,
    input wire logic                            brownout_detector_enable,
    input wire logic                            timer_io_access,
    input wire logic                            adc_io_access,
    input wire logic                            adc_enabled,
    input wire logic                            adc_extended_conversion,
    input wire logic                            comparator_enable,
    input wire logic [5:0]                      input_buffer_enable
);
    import sleep_power_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // the master holds its request, so one wait state must end it
    chk_bus_one_wait: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
        else $error("bus answer missing after one wait state");
    chk_halt_cause: assert property ($rose(cpu_halt) |-> $past(sleep_request))
        else $error("halt without sleep request");
    chk_det_wake_on: assert property ($rose(brownout_detector_enable) |-> cpu_halt && !wake_resume)
        else $error("detector back on outside wake-up");
    chk_det_awake: assert property (!cpu_halt |-> brownout_detector_enable)
        else $error("detector off while running");
    chk_resume_pulse: assert property (wake_resume |-> $past(cpu_halt) && !cpu_halt ##1 !wake_resume)
        else $error("resume pulse malformed");
    chk_halt_tail: assert property ($fell(cpu_halt) |-> $past(cpu_halt, 5))
        else $error("halt shorter than wake plus four cycles");
    chk_cpu_clock_off: assert property (cpu_halt |-> !clock_enable.cpu)
        else $error("cpu clock runs while halted");
    chk_timer_gated: assert property (!timer_io_access |-> !clock_enable.timer)
        else $error("timer clock runs while gated");
    chk_adc_gated: assert property (!adc_io_access |-> !clock_enable.adc_gated && !comparator_enable)
        else $error("adc or comparator alive while gated");
    chk_buffers_awake: assert property (!cpu_halt |-> input_buffer_enable == 6'h3F)
        else $error("input buffers off while running");
    chk_ext_set: assert property ($rose(adc_enabled) |-> ##[1:2] adc_extended_conversion)
        else $error("extended conversion not flagged");
    cover property ($fell(brownout_detector_enable));
    cover property (wake_resume);
    cover property ($fell(adc_io_access));
endmodule : sleep_power_props
bind sleep_power_control sleep_power_props sleep_power_props_inst (.clk, .rst_n, .avs_req, .avs_rsp,
    .sleep_request, .cpu_halt, .wake_resume, .clock_enable, .brownout_detector_enable, .timer_io_access,
    .adc_io_access, .adc_enabled, .adc_extended_conversion, .comparator_enable, .input_buffer_enable);
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the sleep and power control block
// assumes short wake counts through parameters; reads are checked from a queue of expectations
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sleep_power_pkg::*;
    localparam int BW = 20;
    localparam int SU = 3;
    logic           clk = 0, rst_n = 0, sleep_req = 0, wake_req = 0, adc_en = 0, conv = 0, bg = 0;
    avalon_req_t    req = '0;
    avalon_rsp_t    rsp;
    clock_enables_t ce;
    logic [5:0]     mask = 6'h00, ibe;
    logic           halt, resume, det, tio, aio, ext, cmp;
    int             err_count = 0, total_checks = 0, cyc = 0;
    logic [31:0]    exp_q[$];
    sleep_power_control #(.BOD_WAKE_CYCLES_P(BW), .STARTUP_CYCLES_P(SU)) sleep_power_control_inst (
        .clk, .rst_n, .avs_req(req), .avs_rsp(rsp), .sleep_request(sleep_req), .wake_request(wake_req),
        .cpu_halt(halt), .wake_resume(resume), .clock_enable(ce), .brownout_detector_enable(det),
        .timer_io_access(tio), .adc_io_access(aio), .adc_enabled(adc_en), .adc_conversion_start(conv),
        .comparator_uses_bandgap(bg), .adc_extended_conversion(ext), .comparator_enable(cmp),
        .wake_pin_mask(mask), .input_buffer_enable(ibe));
    initial forever #4 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // the request rises after a rising edge and stands until the edge that sees waitrequest low
    task automatic bus(logic wr, logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        req.read <= !wr; req.write <= wr; req.address <= a; req.byteenable <= 4'hF;
        req.writedata <= {24'($urandom), d};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        req.read <= 1'b0; req.write <= 1'b0;
    endtask : bus
    task automatic rd(logic [3:0] a, logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd
    always @(posedge clk) if (req.read && rsp.waitrequest === 1'b0) check("readdata", rsp.readdata, exp_q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            close_out();
        end
    end
    task automatic pulse_sleep();
        @(posedge clk) sleep_req <= 1'b1;
        @(posedge clk) sleep_req <= 1'b0;
        @(negedge clk);
    endtask : pulse_sleep
    task automatic nap(logic [1:0] m, int n);
        int k;
        pulse_sleep();
        check("halt", halt, 1'b1);
        check("io clock", ce.io, m == MODE_IDLE);
        check("adc clock", ce.adc, m != MODE_POWER_DOWN);
        check("buffers", ibe, (m == MODE_POWER_DOWN) ? mask : 6'h3F);
        check("comparator", cmp, m != MODE_POWER_DOWN || bg);
        check("detector", det, n != BW);
        @(posedge clk) wake_req <= 1'b1;
        @(posedge clk) wake_req <= 1'b0;
        k = 0;
        while (k < 200) begin
            @(negedge clk);
            if (resume === 1'b1) break;
            @(posedge clk);
            k++;
        end
        check("wake cycles", k, n + HALT_CYCLES);
        check("detector awake", det, 1'b1);
    endtask : nap
    initial begin
        void'($urandom(32'h5970));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFS_BROWNOUT_SLEEP_CONTROL, 32'h0);
        rd(OFS_PERIPHERAL_CLOCK_GATE, 32'h0);
        bus(1'b1, OFS_SLEEP_CONTROL, 8'hFF);
        rd(OFS_SLEEP_CONTROL, 32'h38);
        bus(1'b1, OFS_PERIPHERAL_CLOCK_GATE, 8'hFF);
        rd(OFS_PERIPHERAL_CLOCK_GATE, 32'h3);
        rd(4'h2, 32'h0);
        $display("register map test done");
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h02);
        rd(OFS_BROWNOUT_SLEEP_CONTROL, 32'h0);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h03);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h02);
        rd(OFS_BROWNOUT_SLEEP_CONTROL, 32'h2);
        rd(OFS_POWER_STATUS, 32'h0D);
        repeat (8) @(posedge clk);
        rd(OFS_BROWNOUT_SLEEP_CONTROL, 32'h0);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h03);
        repeat (6) @(posedge clk);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h02);
        rd(OFS_BROWNOUT_SLEEP_CONTROL, 32'h0);
        $display("unlock test done");
        @(negedge clk);
        check("timer access", tio, 1'b0);
        check("adc access", aio, 1'b0);
        bus(1'b1, OFS_PERIPHERAL_CLOCK_GATE, 8'h00);
        @(negedge clk);
        check("timer clock", ce.timer, 1'b1);
        check("adc clock", ce.adc_gated, 1'b1);
        $display("clock gate test done");
        pulse_sleep();
        check("reserved mode", halt, 1'b0);
        bus(1'b1, OFS_SLEEP_CONTROL, 8'h10);
        pulse_sleep();
        check("unarmed", halt, 1'b0);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mask <= 6'($urandom);
            bg <= 1'($urandom);
            bus(1'b1, OFS_SLEEP_CONTROL, 8'h20 | 8'(m << 3));
            nap(2'(m), SU);
            bus(1'b1, OFS_SLEEP_CONTROL, 8'h00);
        end
        bus(1'b1, OFS_SLEEP_CONTROL, 8'h30);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h03);
        bus(1'b1, OFS_BROWNOUT_SLEEP_CONTROL, 8'h02);
        repeat (2) @(posedge clk);
        nap(MODE_POWER_DOWN, BW);
        bus(1'b1, OFS_SLEEP_CONTROL, 8'h00);
        $display("sleep test done");
        @(posedge clk) adc_en <= 1'b1;
        repeat (3) @(negedge clk);
        check("extended", ext, 1'b1);
        @(posedge clk) conv <= 1'b1;
        @(posedge clk) conv <= 1'b0;
        @(negedge clk);
        check("extended cleared", ext, 1'b0);
        $display("adc test done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
